// File: design/sto_pkg.sv
// constants and types for the torque cutoff supervisor
package sto_pkg;
    localparam int unsigned FAULT_W = 8;
    localparam int unsigned WARN_W = 14;
    localparam int unsigned CODE_W = 12;
    // display code for the torque cutoff alarm, 0x206 shown as P206
    localparam logic [11:0] CODE_CUTOFF = 12'h206;
    localparam logic [11:0] CODE_NONE = 12'h000;
    // fault codes shown as 0x1nn with nn the fault bit index plus one
    localparam logic [11:0] CODE_FAULT_BASE = 12'h100;
    localparam logic [11:0] CODE_WARN_BASE = 12'h200;
    localparam logic [11:0] CODE_CUTOFF_WARN = 12'h220;
    typedef enum logic [1:0] {
        STO_ST_OFF = 2'b00,
        STO_ST_RUN = 2'b01,
        STO_ST_CUT = 2'b10,
        STO_ST_WAIT = 2'b11
    } sto_state_t;
endpackage

// File: design/sto_supervisor.sv
// torque cutoff and alarm supervisor for the servo power stage
`timescale 1ns/1ps
`default_nettype none
module sto_supervisor #(
    parameter int unsigned GATES = 6
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // safety inputs from pins, high means input on
    input wire logic safety_input_a_i,
    input wire logic safety_input_b_i,
    // drive control, same clock domain
    input wire logic enable_cmd_i,
    input wire logic [GATES-1:0] pwm_gate_i,
    input wire logic [sto_pkg::FAULT_W-1:0] fault_i,
    input wire logic [sto_pkg::WARN_W-1:0] warn_i,
    // power stage and status
    output logic [GATES-1:0] pwm_gate_o,
    output logic servo_on_o,
    output logic cutoff_active_o,
    output logic safety_monitor_output_o,
    output logic [sto_pkg::CODE_W-1:0] alarm_code_o,
    output logic [sto_pkg::WARN_W-1:0] warn_flags_o
);
    initial begin
        if (GATES < 1 || GATES > 16) begin
            $error("sto_supervisor: GATES must be 1 to 16");
        end
    end

    logic [1:0] safe_s;
    // reset to off: cutoff holds until the inputs are seen on
    sto_sync #(
        .WIDTH(2),
        .RST_VAL(2'b00)
    ) u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i({safety_input_b_i, safety_input_a_i}),
        .sync_o(safe_s)
    );

    sto_pkg::sto_state_t state_q, state_d;
    logic enable_prev_q;
    logic [GATES-1:0] pwm_gate_q;
    logic servo_on_q;
    logic cutoff_q;
    logic monitor_q;
    logic [sto_pkg::CODE_W-1:0] code_q;
    logic [sto_pkg::WARN_W-1:0] warn_q;

    wire cutoff_req = ~(safe_s[0] & safe_s[1]);
    wire both_off = ~safe_s[0] & ~safe_s[1];
    wire both_on = safe_s[0] & safe_s[1];
    wire enable_rise = enable_cmd_i & ~enable_prev_q;
    wire any_fault = |fault_i;
    // lowest set fault index picks the shown fault code
    logic [sto_pkg::CODE_W-1:0] fault_code;
    always_comb begin
        fault_code = sto_pkg::CODE_NONE;
        for (int i = sto_pkg::FAULT_W - 1; i >= 0; i--) begin
            if (fault_i[i]) begin
                fault_code = sto_pkg::CODE_FAULT_BASE + 12'(i + 1);
            end
        end
    end

    // cutoff is checked first so no other protection can override it
    always_comb begin
        state_d = state_q;
        case (state_q)
            sto_pkg::STO_ST_OFF: begin
                if (cutoff_req) begin
                    state_d = sto_pkg::STO_ST_CUT;
                end else if (enable_rise && !any_fault) begin
                    state_d = sto_pkg::STO_ST_RUN;
                end
            end
            sto_pkg::STO_ST_RUN: begin
                if (cutoff_req) begin
                    state_d = sto_pkg::STO_ST_CUT;
                end else if (any_fault || !enable_cmd_i) begin
                    state_d = sto_pkg::STO_ST_OFF;
                end
            end
            sto_pkg::STO_ST_CUT: begin
                if (both_on) begin
                    state_d = sto_pkg::STO_ST_WAIT;
                end
            end
            sto_pkg::STO_ST_WAIT: begin
                // a held enable does not restart; a new rising edge is needed
                if (cutoff_req) begin
                    state_d = sto_pkg::STO_ST_CUT;
                end else if (enable_rise && !any_fault) begin
                    state_d = sto_pkg::STO_ST_RUN;
                end
            end
            default: begin
                state_d = sto_pkg::STO_ST_CUT;
            end
        endcase
    end

    // outputs follow the next state so the cutoff reaches the pins with the state
    wire run_d = (state_d == sto_pkg::STO_ST_RUN);
    wire cut_d = (state_d == sto_pkg::STO_ST_CUT);
    wire [GATES-1:0] gate_d = run_d ? pwm_gate_i : '0;
    logic [sto_pkg::CODE_W-1:0] code_d;
    always_comb begin
        if (cut_d) begin
            code_d = sto_pkg::CODE_CUTOFF;
        end else if (any_fault) begin
            code_d = fault_code;
        end else if (|warn_i) begin
            code_d = sto_pkg::CODE_WARN_BASE;
        end else begin
            code_d = sto_pkg::CODE_NONE;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= sto_pkg::STO_ST_CUT;
            enable_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            enable_prev_q <= enable_cmd_i;
        end
    end

    // the synchroniser resets to both off, so the monitor is held low until real pin values have passed
    // both flops; otherwise a reset would show the safety controller a false both-off pattern
    logic [1:0] primed_q;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            primed_q <= 2'h0;
        end else begin
            primed_q <= {primed_q[0], 1'h1};
        end
    end
    wire monitor_d = both_off & primed_q[1];

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pwm_gate_q <= '0;
            servo_on_q <= 1'b0;
            cutoff_q <= 1'b1;
            monitor_q <= 1'b0;
            code_q <= sto_pkg::CODE_CUTOFF;
            warn_q <= '0;
        end else begin
            pwm_gate_q <= gate_d;
            servo_on_q <= run_d;
            cutoff_q <= cut_d;
            monitor_q <= monitor_d;
            code_q <= code_d;
            warn_q <= warn_i;
        end
    end

    assign pwm_gate_o = pwm_gate_q;
    assign servo_on_o = servo_on_q;
    assign cutoff_active_o = cutoff_q;
    assign safety_monitor_output_o = monitor_q;
    assign alarm_code_o = code_q;
    assign warn_flags_o = warn_q;

    // checks
    gate_off_cut_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cutoff_active_o |-> (pwm_gate_o == '0 && !servo_on_o))
        else $error("gates or servo on during cutoff");
    cut_enter_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cutoff_req |=> cutoff_active_o)
        else $error("cutoff not entered one cycle after input off");
    fault_prio_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cutoff_req && any_fault) |=> alarm_code_o == sto_pkg::CODE_CUTOFF)
        else $error("fault code shown over cutoff");
    code_cut_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cutoff_active_o |-> alarm_code_o == sto_pkg::CODE_CUTOFF)
        else $error("cutoff code missing");
    // pin-level checks: two sync flops plus the output register put outputs three edges behind the pins
    monitor_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ##3 safety_monitor_output_o == (!$past(safety_input_a_i, 3) && !$past(safety_input_b_i, 3)))
        else $error("monitor output wrong");
    fault_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        any_fault |=> !servo_on_o)
        else $error("servo on with fault");
    warn_keep_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (servo_on_o && |warn_i && !any_fault && !cutoff_req && enable_cmd_i) |=> servo_on_o)
        else $error("warning changed enable state");
    fresh_en_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cutoff_active_o ##1 !cutoff_active_o) |-> !servo_on_o)
        else $error("servo on without fresh enable");
    no_run_held_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_q == sto_pkg::STO_ST_WAIT && !enable_rise) |=> !servo_on_o)
        else $error("servo on from held enable");
    pin_cut_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (!safety_input_a_i || !safety_input_b_i) |-> ##3 cutoff_active_o)
        else $error("cutoff missed after input off");
    leave_cut_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $fell(cutoff_active_o) |-> ($past(safety_input_a_i, 3) && $past(safety_input_b_i, 3)))
        else $error("cutoff left while an input was off");
    gate_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pwm_gate_o == (servo_on_o ? $past(pwm_gate_i) : '0))
        else $error("gates not forced off outside run");
    rise_fresh_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(servo_on_o) |-> ($past(enable_cmd_i) && !$past(enable_cmd_i, 2) && $past(fault_i) == '0))
        else $error("servo started without fresh enable");
    warn_pass_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ##1 warn_flags_o == $past(warn_i))
        else $error("warning flags not passed");

    cut_seen_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        servo_on_o ##1 cutoff_active_o);
    restart_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_q == sto_pkg::STO_ST_WAIT) ##[1:20] servo_on_o);
    monitor_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        safety_monitor_output_o);
    fault_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        servo_on_o ##1 (any_fault && !cutoff_req));
    one_off_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        cutoff_active_o && !safety_monitor_output_o && safe_s != 2'h0);
endmodule
`default_nettype wire

// File: design/sto_sync.sv
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module sto_sync #(
    parameter int unsigned WIDTH = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    initial begin
        if (WIDTH < 1) begin
            $error("sto_sync: WIDTH must be at least 1");
        end
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

// File: test/sto_safety_ctrl.sv
// model of the external safety controller driving both safety inputs
`timescale 1ns/1ps
`default_nettype none
module sto_safety_ctrl (
    // requested contact states, bit1 is input a, 1 means on
    input wire logic [1:0] step_i,
    // safety pins, high means on
    output logic safety_input_a_o,
    output logic safety_input_b_o
);
    // the bench steps all four combinations and judges the monitor
    assign safety_input_a_o = step_i[1];
    assign safety_input_b_o = step_i[0];
endmodule
`default_nettype wire

// File: test/test_sto_supervisor.sv
// self-checking bench for the torque cutoff supervisor
`timescale 1ns/1ps
`default_nettype none
module test_sto_supervisor;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic enable_cmd_i = 1'b0;
    logic [1:0] step = 2'b11;
    logic [5:0] pwm_gate_i = 6'h2d;
    logic [7:0] fault_i = 8'h00;
    logic [13:0] warn_i = 14'h0000;
    wire logic pin_a;
    wire logic pin_b;
    logic [5:0] pwm_gate_o;
    logic servo_on_o;
    logic cutoff_active_o;
    logic safety_monitor_output_o;
    logic [11:0] alarm_code_o;
    logic [13:0] warn_flags_o;
    int errors = 0;
    int compares = 0;

    sto_safety_ctrl u_ctrl (.step_i(step), .safety_input_a_o(pin_a), .safety_input_b_o(pin_b));
    sto_supervisor #(.GATES(6)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .safety_input_a_i(pin_a),
        .safety_input_b_i(pin_b), .enable_cmd_i(enable_cmd_i), .pwm_gate_i(pwm_gate_i), .fault_i(fault_i),
        .warn_i(warn_i), .pwm_gate_o(pwm_gate_o), .servo_on_o(servo_on_o), .cutoff_active_o(cutoff_active_o),
        .safety_monitor_output_o(safety_monitor_output_o), .alarm_code_o(alarm_code_o),
        .warn_flags_o(warn_flags_o));

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // a fresh rising edge of the enable request
    task automatic restart;
        @(posedge clk_i);
        enable_cmd_i <= 1'b0;
        @(posedge clk_i);
        enable_cmd_i <= 1'b1;
        tick(2);
    endtask

    task automatic t_monitor;
        for (int i = 3; i >= 0; i--) begin
            @(posedge clk_i);
            step <= i[1:0];
            tick(4);
            check(safety_monitor_output_o, i == 0, "monitor");
            check(cutoff_active_o, i != 3, "cutoff");
            if (i != 3) check(alarm_code_o, 12'h206, "cutoff code");
        end
        @(posedge clk_i);
        step <= 2'b11;
        tick(4);
    endtask

    task automatic t_faults;
        for (int i = 0; i < 8; i++) begin
            restart();
            check(servo_on_o, 1'b1, "servo on");
            check(pwm_gate_o, pwm_gate_i, "gates pass");
            @(posedge clk_i);
            fault_i <= 8'h01 << i;
            tick(2);
            check(servo_on_o, 1'b0, "fault servo");
            check(pwm_gate_o, 6'h00, "fault gates");
            check(alarm_code_o, 12'h100 + i + 1, "fault code");
            @(posedge clk_i);
            fault_i <= 8'h00;
        end
    endtask

    task automatic t_warn;
        restart();
        @(posedge clk_i);
        warn_i <= 14'h2a55;
        pwm_gate_i <= 6'h12;
        tick(2);
        check(servo_on_o, 1'b1, "warn servo");
        check(warn_flags_o, 14'h2a55, "warn flags");
        check(alarm_code_o, 12'h200, "warn code");
        check(pwm_gate_o, 6'h12, "warn gates");
        @(posedge clk_i);
        warn_i <= 14'h0000;
    endtask

    task automatic t_cut;
        @(posedge clk_i);
        fault_i <= 8'h08;
        step <= 2'b01;
        tick(4);
        check(alarm_code_o, 12'h206, "priority code");
        check(pwm_gate_o, 6'h00, "cut gates");
        check(servo_on_o, 1'b0, "cut servo");
        @(posedge clk_i);
        fault_i <= 8'h00;
        step <= 2'b11;
        tick(4);
        check(cutoff_active_o, 1'b0, "cut left");
        check(servo_on_o, 1'b0, "no fresh enable");
        restart();
        check(servo_on_o, 1'b1, "re-enabled");
    endtask

    // reset in mid-run: outputs fall back to cutoff, the monitor shows no false both-off pattern
    task automatic t_reset;
        restart();
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        tick(2);
        check(servo_on_o, 1'b0, "reset servo");
        check(cutoff_active_o, 1'b1, "reset cut");
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        tick(2);
        check(safety_monitor_output_o, 1'b0, "reset monitor");
        tick(2);
        check(cutoff_active_o, 1'b0, "reset left");
        check(servo_on_o, 1'b0, "reset no enable");
        restart();
        check(servo_on_o, 1'b1, "reset re-enabled");
    endtask

    task automatic conclude;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        tick(9);
        check(cutoff_active_o, 1'b1, "reset cutoff");
        check(alarm_code_o, 12'h206, "reset code");
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        tick(4);
        t_monitor();
        t_faults();
        t_warn();
        t_cut();
        t_reset();
        conclude();
    end

    // cuts a hang short
    initial begin
        #1ms;
        errors++;
        conclude();
    end
endmodule
`default_nettype wire
